// >>> core/edge_timestamp_capture.sv
// Purpose: Two channel edge timestamp capture with APB registers
// Assumes: Time bases, idle and sleep come from logic on CLOCK
// Notes: Capture pins are asynchronous and pass a two-stage synchroniser
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module edge_timestamp_capture (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [1:0] CAP_PIN,
	input wire capture_pkg::tb_s TB_FIRST,
	input wire capture_pkg::tb_s TB_SECOND,
	input wire logic CPU_IDLE,
	input wire logic CPU_SLEEP,
	output logic [1:0] IRQ_FLAG,
	output logic [1:0] WAKE_REQ
);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] wake;
		capture_pkg::chan_s [1:0] ch;
	} top_s;

	top_s st_reg;
	top_s st_next;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] push;
	logic [1:0] pop;
	logic [1:0][15:0] din;
	logic [1:0][15:0] head;
	logic [1:0][2:0] cnt;
	logic [31:0] rdata;
	logic hit;
	logic commit;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Qualifying edge for a mode, prescaled modes at their terminal count
	function automatic logic edge_event(input capture_pkg::mode_e m, input logic r,
			input logic f, input logic [3:0] p);
		logic e;
		e = 1'b0;
		case (m)
			capture_pkg::MODE_BOTH: e = r | f;
			capture_pkg::MODE_FALL: e = f;
			capture_pkg::MODE_RISE: e = r;
			capture_pkg::MODE_RISE4: e = r && p == capture_pkg::PRESC_LAST4;
			capture_pkg::MODE_RISE16: e = r && p == capture_pkg::PRESC_LAST16;
			capture_pkg::MODE_WAKE: e = r;
			default: e = 1'b0;
		endcase
		return e;
	endfunction

	// Control register image with live status bits
	function automatic logic [31:0] con_image(input capture_pkg::chan_s c,
			input logic [2:0] n);
		logic [31:0] v;
		v = 32'h0;
		v[capture_pkg::CON_SIDL] = c.con.sidl;
		v[capture_pkg::CON_TSEL] = c.con.tsel;
		v[capture_pkg::CON_EPI +: 2] = c.con.epi;
		v[capture_pkg::CON_OVF] = c.ovf;
		v[capture_pkg::CON_BNE] = n != capture_pkg::CNT_RST;
		v[capture_pkg::CON_MODE +: 3] = c.con.mode;
		return v;
	endfunction

	// Control fields taken from write data
	function automatic capture_pkg::con_s con_write(input logic [31:0] d);
		capture_pkg::con_s c;
		c.sidl = d[capture_pkg::CON_SIDL];
		c.tsel = d[capture_pkg::CON_TSEL];
		c.epi = d[capture_pkg::CON_EPI +: 2];
		c.mode = capture_pkg::mode_e'(d[capture_pkg::CON_MODE +: 3]);
		return c;
	endfunction

	// ------------------------------------------------------------
	// Per channel pin synchroniser and capture buffer
	// ------------------------------------------------------------
	for (genvar g = 0; g < capture_pkg::NUM_CH; g++) begin : g_ch
		cap_edge_detect u_edge (
			.clk(CLOCK),
			.rst_n(RST_N),
			.pin(CAP_PIN[g]),
			.rise(rise[g]),
			.fall(fall[g])
		);
		cap_fifo u_fifo (
			.clk(CLOCK),
			.rst_n(RST_N),
			.push(push[g]),
			.din(din[g]),
			.pop(pop[g]),
			.head(head[g]),
			.cnt(cnt[g])
		);
	end

	// ------------------------------------------------------------
	// Register read decode
	// ------------------------------------------------------------
	always_comb begin
		rdata = 32'h0;
		hit = 1'b1;
		case (PADDR)
			capture_pkg::OFS_CON0: rdata = con_image(st_reg.ch[0], cnt[0]);
			capture_pkg::OFS_BUF0: rdata = {16'h0, head[0]};
			capture_pkg::OFS_CON1: rdata = con_image(st_reg.ch[1], cnt[1]);
			capture_pkg::OFS_BUF1: rdata = {16'h0, head[1]};
			capture_pkg::OFS_IRQ: begin
				rdata[capture_pkg::IRQ_FLAG +: 2] = {st_reg.ch[1].flag, st_reg.ch[0].flag};
				rdata[capture_pkg::IRQ_EN +: 2] = {st_reg.ch[1].ien, st_reg.ch[0].ien};
			end
			default: hit = 1'b0;
		endcase
	end

	// Write and pop happen on the edge where PREADY is seen high
	assign commit = PSEL & PENABLE & st_reg.pready;

	// ------------------------------------------------------------
	// Next state: bus answer, register writes, channel behaviour
	// ------------------------------------------------------------
	always_comb begin
		capture_pkg::chan_s c;
		capture_pkg::tb_s tb;
		logic live;
		logic lowpwr;
		logic ev;
		logic stored;
		c = '0;
		tb = '0;
		live = 1'b0;
		lowpwr = 1'b0;
		ev = 1'b0;
		stored = 1'b0;
		st_next = st_reg;
		push = '0;
		pop = '0;
		din = '0;

		// One wait state so that read data leaves a flip-flop
		st_next.pready = PSEL & PENABLE & ~st_reg.pready;
		st_next.pslverr = PSEL & PENABLE & ~st_reg.pready & ~hit;
		if (PSEL && PENABLE && !st_reg.pready) begin
			st_next.prdata = rdata;
		end

		for (int i = 0; i < capture_pkg::NUM_CH; i++) begin
			c = st_reg.ch[i];
			// Software side first, so hardware sets override clears
			if (commit && PWRITE) begin
				if (PADDR == (i == 0 ? capture_pkg::OFS_CON0 : capture_pkg::OFS_CON1)) begin
					c.con = con_write(PWDATA);
				end
				if (PADDR == capture_pkg::OFS_IRQ) begin
					c.ien = PWDATA[capture_pkg::IRQ_EN + i];
					if (PWDATA[capture_pkg::IRQ_FLAG + i]) begin
						c.flag = 1'b0;
					end
				end
			end
			// Empty reads are not popped; their data is undefined anyway
			if (commit && !PWRITE && cnt[i] != capture_pkg::CNT_RST &&
					PADDR == (i == 0 ? capture_pkg::OFS_BUF0 : capture_pkg::OFS_BUF1)) begin
				pop[i] = 1'b1;
			end

			// Time base selection, 0 picks the second time base
			tb = st_reg.ch[i].con.tsel ? TB_FIRST : TB_SECOND;
			lowpwr = CPU_SLEEP | CPU_IDLE;
			// Sleep halts the time bases; idle needs stop-in-idle clear
			live = tb.on && !CPU_SLEEP &&
				!(CPU_IDLE && st_reg.ch[i].con.sidl);
			ev = edge_event(st_reg.ch[i].con.mode, rise[i], fall[i], st_reg.ch[i].presc);

			// Prescaler: held clear while off, counts rising edges
			if (st_reg.ch[i].con.mode == capture_pkg::MODE_OFF) begin
				c.presc = capture_pkg::PRESC_RST;
				c.icnt = capture_pkg::ICNT_RST;
			end else if (live && rise[i] &&
					(st_reg.ch[i].con.mode == capture_pkg::MODE_RISE4 ||
					st_reg.ch[i].con.mode == capture_pkg::MODE_RISE16)) begin
				c.presc = ev ? capture_pkg::PRESC_RST : st_reg.ch[i].presc + 4'h1;
			end

			// Wake-only path works without a running time base
			if (lowpwr && st_reg.ch[i].con.mode == capture_pkg::MODE_WAKE && rise[i]) begin
				c.flag = 1'b1;
			end else if (live && ev) begin
				if (st_reg.ch[i].ovf) begin
					stored = 1'b0;
				end else if (cnt[i] == capture_pkg::CNT_FULL) begin
					// Both-edges mode drops the stamp but still flags the edge
					if (st_reg.ch[i].con.mode != capture_pkg::MODE_BOTH) begin
						c.ovf = 1'b1;
					end else begin
						c.flag = 1'b1;
					end
				end else begin
					stored = 1'b1;
				end
			end
			if (stored) begin
				push[i] = 1'b1;
				din[i] = tb.count;
				if (st_reg.ch[i].con.mode == capture_pkg::MODE_BOTH ||
						st_reg.ch[i].con.mode == capture_pkg::MODE_WAKE) begin
					c.flag = 1'b1;
				end else if (st_reg.ch[i].icnt == st_reg.ch[i].con.epi) begin
					c.flag = 1'b1;
					c.icnt = capture_pkg::ICNT_RST;
				end else begin
					c.icnt = st_reg.ch[i].icnt + 2'h1;
				end
			end
			stored = 1'b0;

			// Overflow ends once the buffer has been read out
			if (pop[i] && cnt[i] == 3'h1 && !push[i]) begin
				c.ovf = 1'b0;
			end
			st_next.wake[i] = c.flag & c.ien & lowpwr;
			st_next.ch[i] = c;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg.prdata <= 32'h0;
			st_reg.pready <= 1'b0;
			st_reg.pslverr <= 1'b0;
			st_reg.wake <= 2'h0;
			// Reset control selects the second time base, mode off
			for (int i = 0; i < capture_pkg::NUM_CH; i++) begin
				st_reg.ch[i] <= '{con: capture_pkg::CON_RST, ovf: 1'b0,
					presc: capture_pkg::PRESC_RST, icnt: capture_pkg::ICNT_RST,
					flag: 1'b0, ien: 1'b0};
			end
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all from flip-flops
	// ------------------------------------------------------------
	assign PRDATA = st_reg.prdata;
	assign PREADY = st_reg.pready;
	assign PSLVERR = st_reg.pslverr;
	assign IRQ_FLAG = {st_reg.ch[1].flag, st_reg.ch[0].flag};
	assign WAKE_REQ = st_reg.wake;

	// ------------------------------------------------------------
	// Checks per channel
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	for (genvar g = 0; g < capture_pkg::NUM_CH; g++) begin : g_chk
		logic is_both;
		logic live_c;
		assign is_both = st_reg.ch[g].con.mode == capture_pkg::MODE_BOTH;
		assign live_c = (st_reg.ch[g].con.tsel ? TB_FIRST.on : TB_SECOND.on) &&
			!CPU_SLEEP && !(CPU_IDLE && st_reg.ch[g].con.sidl);

		sequence s_full_event;
			live_c && cnt[g] == 3'h4 && !st_reg.ch[g].ovf && !is_both &&
			st_reg.ch[g].con.mode != capture_pkg::MODE_OFF &&
			!(CPU_IDLE && st_reg.ch[g].con.mode == capture_pkg::MODE_WAKE) &&
			edge_event(st_reg.ch[g].con.mode, rise[g], fall[g], st_reg.ch[g].presc);
		endsequence

		property p_presc_off;
			st_reg.ch[g].con.mode == capture_pkg::MODE_OFF |=> st_reg.ch[g].presc == 4'h0;
		endproperty
		a_presc_off: assert property (p_presc_off) else $error("prescaler not cleared");

		property p_ovf_set;
			s_full_event |=> st_reg.ch[g].ovf && cnt[g] == 3'h4;
		endproperty
		a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

		property p_ovf_block;
			st_reg.ch[g].ovf |-> !push[g];
		endproperty
		a_ovf_block: assert property (p_ovf_block) else $error("capture after overflow");

		property p_both_noovf;
			$rose(st_reg.ch[g].ovf) |-> !$past(is_both);
		endproperty
		a_both_noovf: assert property (p_both_noovf) else $error("overflow in both edges");

		property p_both_flag;
			is_both && push[g] |=> st_reg.ch[g].flag;
		endproperty
		a_both_flag: assert property (p_both_flag) else $error("both edges missed flag");

		property p_tsel;
			push[g] |-> din[g] == (st_reg.ch[g].con.tsel ? TB_FIRST.count : TB_SECOND.count);
		endproperty
		a_tsel: assert property (p_tsel) else $error("wrong time base captured");

		property p_sleep_quiet;
			CPU_SLEEP |-> !push[g];
		endproperty
		a_sleep_quiet: assert property (p_sleep_quiet) else $error("capture during sleep");

		sequence s_wake_edge;
			CPU_SLEEP && st_reg.ch[g].ien &&
			st_reg.ch[g].con.mode == capture_pkg::MODE_WAKE && rise[g];
		endsequence

		property p_wake;
			s_wake_edge ##1 CPU_SLEEP |-> st_reg.ch[g].flag && WAKE_REQ[g];
		endproperty
		a_wake: assert property (p_wake) else $error("sleep wake-up missing");

		property p_bne;
			push[g] && cnt[g] == 3'h0 |=> cnt[g] == 3'h1;
		endproperty
		a_bne: assert property (p_bne) else $error("buffer not empty missed");
	end

endmodule

`default_nettype wire

// >>> core/capture_pkg.sv
// Purpose: Shared constants, types and register map of the edge timestamp capture block
// Assumes: 25 MHz CLOCK, APB register access, two capture channels

package capture_pkg;

	// ------------------------------------------------------------
	// Sizes and register map
	// ------------------------------------------------------------
	localparam int NUM_CH = 2;
	localparam int DATA_W = 16;
	localparam int DEPTH = 4;
	localparam logic [7:0] OFS_CON0 = 8'h00;
	localparam logic [7:0] OFS_BUF0 = 8'h04;
	localparam logic [7:0] OFS_CON1 = 8'h08;
	localparam logic [7:0] OFS_BUF1 = 8'h0c;
	localparam logic [7:0] OFS_IRQ = 8'h10;

	// Field positions of the channel control register
	localparam int CON_SIDL = 13;
	localparam int CON_TSEL = 7;
	localparam int CON_EPI = 5;
	localparam int CON_OVF = 4;
	localparam int CON_BNE = 3;
	localparam int CON_MODE = 0;
	// Field positions of the flag and enable register
	localparam int IRQ_FLAG = 0;
	localparam int IRQ_EN = 8;

	// Prescaler terminal counts and reset values
	localparam logic [3:0] PRESC_RST = 4'h0;
	localparam logic [3:0] PRESC_LAST4 = 4'h3;
	localparam logic [3:0] PRESC_LAST16 = 4'hf;
	localparam logic [1:0] ICNT_RST = 2'h0;
	localparam logic [2:0] CNT_RST = 3'h0;
	localparam logic [2:0] CNT_FULL = 3'h4;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0,
		MODE_BOTH = 3'h1,
		MODE_FALL = 3'h2,
		MODE_RISE = 3'h3,
		MODE_RISE4 = 3'h4,
		MODE_RISE16 = 3'h5,
		MODE_SPARE = 3'h6,
		MODE_WAKE = 3'h7
	} mode_e;

	typedef struct packed {
		logic [15:0] count;
		logic on;
	} tb_s;

	typedef struct packed {
		logic sidl;
		logic tsel;
		logic [1:0] epi;
		mode_e mode;
	} con_s;

	localparam con_s CON_RST = '{sidl: 1'b0, tsel: 1'b0, epi: 2'h0, mode: MODE_OFF};

	typedef struct packed {
		con_s con;
		logic ovf;
		logic [3:0] presc;
		logic [1:0] icnt;
		logic flag;
		logic ien;
	} chan_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
	} edge_s;

	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] mem;
		logic [2:0] cnt;
	} fifo_s;

endpackage

// >>> core/cap_edge_detect.sv
// Purpose: Synchronise a capture pin and report rising and falling edges
// Assumes: Pin is asynchronous to CLOCK
// Notes: Edge pulses last one cycle, one to two cycles after the pin moves
`timescale 1ns/1ns
`default_nettype none

module cap_edge_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic rise,
	output logic fall
);

	capture_pkg::edge_s st_reg;
	capture_pkg::edge_s st_next;

	// ------------------------------------------------------------
	// Two-stage synchroniser, then previous value for edge compare
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin;
		st_next.s2 = st_reg.s1;
		st_next.prev = st_reg.s2;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Only the second stage and its delayed copy feed edge logic
	assign rise = st_reg.s2 & ~st_reg.prev;
	assign fall = ~st_reg.s2 & st_reg.prev;

	property p_edge_single;
		@(posedge clk) disable iff (!rst_n) (rise | fall) |=> !(rise | fall);
	endproperty
	a_edge_single: assert property (p_edge_single) else $error("edge pulse too long");

endmodule

`default_nettype wire

// >>> core/cap_fifo.sv
// Purpose: Four entry shift FIFO holding captured time base values
// Assumes: Caller never pushes when full
// Notes: Head is entry 0; a pop shifts every entry down by one
`timescale 1ns/1ns
`default_nettype none

module cap_fifo (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [15:0] din,
	input wire logic pop,
	output logic [15:0] head,
	output logic [2:0] cnt
);

	capture_pkg::fifo_s st_reg;
	capture_pkg::fifo_s st_next;
	logic [2:0] base;

	// ------------------------------------------------------------
	// Shift on pop, then write behind the last valid entry
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		base = st_reg.cnt;
		if (pop && st_reg.cnt != capture_pkg::CNT_RST) begin
			for (int i = 0; i < capture_pkg::DEPTH - 1; i++) begin
				st_next.mem[i] = st_reg.mem[i+1];
			end
			base = st_reg.cnt - 3'h1;
		end
		if (push && base != capture_pkg::CNT_FULL) begin
			st_next.mem[base[1:0]] = din;
			base = base + 3'h1;
		end
		st_next.cnt = base;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign head = st_reg.mem[0];
	assign cnt = st_reg.cnt;

	property p_shift;
		@(posedge clk) disable iff (!rst_n)
		pop && !push && st_reg.cnt > 3'h1 |=> head == $past(st_reg.mem[1]);
	endproperty
	a_shift: assert property (p_shift) else $error("fifo did not shift");

	property p_depth;
		@(posedge clk) disable iff (!rst_n) cnt <= capture_pkg::CNT_FULL;
	endproperty
	a_depth: assert property (p_depth) else $error("fifo count above depth");

endmodule

`default_nettype wire

// >>> dv/cap_pin_source.sv
// Purpose: External signal source driving the two capture pins
// Assumes: The bench asks for one pin toggle at a time
// Notes: A lag of 0 to 3 cycles models prompt and slow sources
`timescale 1ns/1ns
`default_nettype none

module cap_pin_source (
	input wire logic clk,
	input wire logic [1:0] go,
	input wire logic [1:0] lag,
	output logic [1:0] pin
);
	logic [1:0] pend;
	logic [1:0] cnt;

	initial begin
		pin = 2'h0;
		pend = 2'h0;
		cnt = 2'h0;
	end

	// Push-pull source: the level holds until the next request
	always @(posedge clk) begin
		if (go != 2'h0) begin
			pend <= go;
			cnt <= lag;
		end else if (pend != 2'h0 && cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end else if (pend != 2'h0) begin
			pin <= pin ^ pend;
			pend <= 2'h0;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_edge_timestamp_capture.sv
// Purpose: Self-checking bench of the edge timestamp capture block
// Assumes: APB slave answers with one wait state; pins toggle via the source model
// Notes: Time base counts change only between edges, so stamps are exact
`timescale 1ns/1ns
`default_nettype none

module tb_edge_timestamp_capture;
	logic CLOCK = 1'b0;
	logic RST_N = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [1:0] CAP_PIN;
	capture_pkg::tb_s TB_FIRST = '{count: 16'h0, on: 1'b1};
	capture_pkg::tb_s TB_SECOND = '{count: 16'h0, on: 1'b1};
	logic CPU_IDLE = 1'b0;
	logic CPU_SLEEP = 1'b0;
	logic [1:0] IRQ_FLAG;
	logic [1:0] WAKE_REQ;
	logic [1:0] go = 2'h0;
	logic [1:0] lag = 2'h0;
	logic [1:0] ien = 2'h0;
	logic [31:0] rd;
	logic er;
	logic [15:0] q[2][$];
	int errors = 0;
	int n_tests = 0;

	always #20 CLOCK = ~CLOCK;

	edge_timestamp_capture uut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CAP_PIN(CAP_PIN), .TB_FIRST(TB_FIRST), .TB_SECOND(TB_SECOND),
		.CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP), .IRQ_FLAG(IRQ_FLAG), .WAKE_REQ(WAKE_REQ));

	cap_pin_source src (.clk(CLOCK), .go(go), .lag(lag), .pin(CAP_PIN));

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Entered just after an edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		// Idle edge so the next request never lands in the same step
		@(posedge CLOCK);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic clr();
		wr(8'h10, {22'h0, ien, 8'h03});
	endtask

	function automatic logic [31:0] con(input logic [2:0] m, input logic [1:0] epi,
		input logic t, input logic bne, input logic ovf);
		con = {24'h0, t, epi, ovf, bne, m};
	endfunction

	// One pin toggle with fresh random stamps on both time bases
	task automatic tog(input int ch, input logic t, input logic cap);
		logic [15:0] a;
		logic [15:0] b;
		a = 16'($urandom);
		b = 16'($urandom);
		TB_FIRST.count <= a;
		TB_SECOND.count <= b;
		go <= 2'(1 << ch);
		lag <= 2'($urandom_range(3));
		@(posedge CLOCK);
		go <= 2'h0;
		repeat (8) @(posedge CLOCK);
		if (cap) q[ch].push_back(t ? a : b);
	endtask

	task automatic pulse(input int ch, input logic t, input logic c1, input logic c2);
		tog(ch, t, c1);
		tog(ch, t, c2);
	endtask

	task automatic drain(input int ch, input logic [31:0] c);
		while (q[ch].size() > 0) begin
			rdc(8'(ch * 8 + 4), {16'h0, q[ch].pop_front()}, "buf");
		end
		rdc(8'(ch * 8), c, "con");
	endtask

	// ----------------------------------------------------------------
	// Watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		#(40 * 40000);
		errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(44));
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'b1;
		@(posedge CLOCK);
		rdc(8'h00, 32'h0, "con0");
		rdc(8'h08, 32'h0, "con1");
		rdc(8'h10, 32'h0, "irq");
		apb(1'b0, 8'h20, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		// Rising capture into a full buffer, then reads during overflow
		wr(8'h00, 32'h3);
		for (int i = 0; i < 6; i++) begin
			pulse(0, 1'b0, i < 4, 1'b0);
		end
		chk("flag0", 32'h1, {31'h0, IRQ_FLAG[0]});
		rdc(8'h00, con(3'h3, 2'h0, 1'b0, 1'b1, 1'b1), "con0");
		repeat (3) rdc(8'h04, {16'h0, q[0].pop_front()}, "buf0");
		pulse(0, 1'b0, 1'b0, 1'b0);
		drain(0, con(3'h3, 2'h0, 1'b0, 1'b0, 1'b0));
		pulse(0, 1'b0, 1'b1, 1'b0);
		drain(0, con(3'h3, 2'h0, 1'b0, 1'b0, 1'b0));
		// Falling capture on channel 1 from the first time base, flag every 2nd
		clr();
		wr(8'h08, con(3'h2, 2'h1, 1'b1, 1'b0, 1'b0));
		pulse(1, 1'b1, 1'b0, 1'b1);
		chk("flag1", 32'h0, {31'h0, IRQ_FLAG[1]});
		pulse(1, 1'b1, 1'b0, 1'b1);
		chk("flag1", 32'h1, {31'h0, IRQ_FLAG[1]});
		chk("flag0", 32'h0, {31'h0, IRQ_FLAG[0]});
		drain(1, con(3'h2, 2'h1, 1'b1, 1'b0, 1'b0));
		// Edge prescaler, cleared by switching the channel off
		wr(8'h00, 32'h4);
		for (int i = 0; i < 6; i++) begin
			pulse(0, 1'b0, i == 3, 1'b0);
		end
		wr(8'h00, 32'h0);
		pulse(0, 1'b0, 1'b0, 1'b0);
		wr(8'h00, 32'h4);
		for (int i = 0; i < 4; i++) begin
			pulse(0, 1'b0, i == 3, 1'b0);
		end
		wr(8'h00, 32'h5);
		for (int i = 0; i < 16; i++) begin
			pulse(0, 1'b0, i == 15, 1'b0);
		end
		drain(0, con(3'h5, 2'h0, 1'b0, 1'b0, 1'b0));
		// Both edges: flag on each edge, grouping ignored, no overflow
		wr(8'h08, con(3'h1, 2'h3, 1'b0, 1'b0, 1'b0));
		for (int i = 0; i < 6; i++) begin
			clr();
			tog(1, 1'b0, i < 4);
			chk("flag1", 32'h1, {31'h0, IRQ_FLAG[1]});
		end
		rdc(8'h08, con(3'h1, 2'h3, 1'b0, 1'b1, 1'b0), "con1");
		drain(1, con(3'h1, 2'h3, 1'b0, 1'b0, 1'b0));
		// Sleep and idle behaviour with the channel 0 enable set
		ien = 2'h1;
		clr();
		TB_FIRST.on <= 1'b0;
		TB_SECOND.on <= 1'b0;
		CPU_SLEEP <= 1'b1;
		wr(8'h00, 32'h67);
		pulse(0, 1'b0, 1'b0, 1'b0);
		chk("flag0", 32'h1, {31'h0, IRQ_FLAG[0]});
		chk("wake0", 32'h1, {31'h0, WAKE_REQ[0]});
		rdc(8'h00, 32'h67, "con0");
		clr();
		TB_FIRST.on <= 1'b1;
		TB_SECOND.on <= 1'b1;
		wr(8'h00, 32'h3);
		pulse(0, 1'b0, 1'b0, 1'b0);
		chk("flag0", 32'h0, {31'h0, IRQ_FLAG[0]});
		CPU_SLEEP <= 1'b0;
		CPU_IDLE <= 1'b1;
		wr(8'h00, 32'h2003);
		pulse(0, 1'b0, 1'b0, 1'b0);
		rdc(8'h00, 32'h2003, "con0");
		wr(8'h00, 32'h3);
		pulse(0, 1'b0, 1'b1, 1'b0);
		chk("wake0", 32'h1, {31'h0, WAKE_REQ[0]});
		CPU_IDLE <= 1'b0;
		drain(0, con(3'h3, 2'h0, 1'b0, 1'b0, 1'b0));
		// Mode 7 in run mode captures each rise and flags each one
		clr();
		wr(8'h00, 32'h27);
		pulse(0, 1'b0, 1'b1, 1'b0);
		chk("flag0", 32'h1, {31'h0, IRQ_FLAG[0]});
		drain(0, con(3'h7, 2'h1, 1'b0, 1'b0, 1'b0));
		report_and_stop();
	end
endmodule
`default_nettype wire
